//--- opdec_defines.svh
// field positions, mode codes and constants of the operand decoder
`ifndef OPDEC_DEFINES_SVH
`define OPDEC_DEFINES_SVH

// ------------------------------------------------------------
// instruction word fields
// ------------------------------------------------------------
`define FLD_CLASS    23:20
`define FLD_OFFREG   19:16
`define FLD_DMODE    15:12
`define FLD_DREG     11:8
`define FLD_SMODE    7:4
`define FLD_SREG     3:0
`define FLD_MAC_XREG 19
`define FLD_MAC_XMD  18:16
`define FLD_MAC_YREG 15
`define FLD_MAC_YMD  14:12
`define FLD_MAC_OFF  11:8
`define FLD_BRA_LIT  15:0
`define FLD_INTERRUPT_DISABLE_INSTR_LIT 13:0
`define FLD_LIT8     11:4
`define FLD_LIT16    19:4

// ------------------------------------------------------------
// instruction classes
// ------------------------------------------------------------
`define CLS_NOP    4'h0
`define CLS_MOVE   4'h1
`define CLS_ACC    4'h2
`define CLS_MAC    4'h3
`define CLS_BRA    4'h4
`define CLS_INTERRUPT_DISABLE_INSTR   4'h5
`define CLS_FRAME_UNLINK_INSTR   4'h6
`define CLS_ORD    4'h7
`define CLS_MOVL8  4'h8
`define CLS_MOVL16 4'h9

// ------------------------------------------------------------
// generic addressing modes
// ------------------------------------------------------------
`define AM_DIRECT  4'h0
`define AM_IND     4'h1
`define AM_POSTINC 4'h2
`define AM_POSTDEC 4'h3
`define AM_PREINC  4'h4
`define AM_PREDEC  4'h5
`define AM_INDEXED 4'h6
`define AM_LITOFF  4'h7

// mac operand modes
`define MM_IND     3'h0
`define MM_POST2   3'h1
`define MM_POST4   3'h2
`define MM_POST6   3'h3
`define MM_INDEXED 3'h4

// ------------------------------------------------------------
// registers and steps
// ------------------------------------------------------------
`define WORD_STEP  3'h2
`define MAC_XBASE  3'h4
`define MAC_YBASE  3'h5
`define REG_FRAME  4'he
`define REG_STACK  4'hf

`endif

//--- opdec_pkg.sv
// shared types of the operand decoder
package opdec_pkg;
  typedef logic [15:0]  word_t;
  typedef logic [3:0]   amode_t;
  typedef logic [2:0]   step_t;
  typedef logic [255:0] regfile_t;
endpackage

//--- agu_if.sv
// request and answer of one address generator
`timescale 1ns/1ns
`default_nettype none
interface agu_if;
  opdec_pkg::amode_t mode;
  opdec_pkg::step_t  step;
  opdec_pkg::word_t  ptr;
  opdec_pkg::word_t  offset;
  opdec_pkg::word_t  ea;
  opdec_pkg::word_t  wb_value;
  logic              wb_en;
  modport gen (
    input  mode, step, ptr, offset,
    output ea, wb_value, wb_en
  );
  modport user (
    output mode, step, ptr, offset,
    input  ea, wb_value, wb_en
  );
endinterface
`default_nettype wire

//--- opdec_agu.sv
// address generator: effective address and pointer write-back
`timescale 1ns/1ns
`default_nettype none
`include "opdec_defines.svh"
module opdec_agu (
  // request and answer
  agu_if.gen a
);
  opdec_pkg::word_t step16;

  // ------------------------------------------------------------
  // address arithmetic
  // ------------------------------------------------------------
  always_comb begin
    step16     = {13'h0000, a.step};
    a.ea       = a.ptr;
    a.wb_value = a.ptr;
    a.wb_en    = 1'b0;
    case (a.mode)
      // access with old pointer, then write back advanced one
      `AM_POSTINC: begin
        a.wb_value = a.ptr + step16;
        a.wb_en    = 1'b1;
      end
      `AM_POSTDEC: begin
        a.wb_value = a.ptr - step16;
        a.wb_en    = 1'b1;
      end
      `AM_PREINC: begin
        a.ea       = a.ptr + step16;
        a.wb_value = a.ptr + step16;
        a.wb_en    = 1'b1;
      end
      `AM_PREDEC: begin
        a.ea       = a.ptr - step16;
        a.wb_value = a.ptr - step16;
        a.wb_en    = 1'b1;
      end
      // register or literal offset, pointer left alone
      `AM_INDEXED,
      `AM_LITOFF: begin
        a.ea = a.ptr + a.offset;
      end
      default: begin
        a.ea = a.ptr;
      end
    endcase
  end
endmodule
`default_nettype wire

//--- operand_address_mode_decode.sv
// operand addressing-mode decoder with x and y address generator steering
// Overview of operation
// - move and accumulator instructions also accept register-offset indexed mode
// - move modes differ per operand; one 4-bit offset field serves both
// - move/accumulator: direct, indirect, pre/post, indexed, literal offset, 8/16-bit literal
// - each instruction class decodes only its own subset of modes
// - multiply-accumulate class decodes a reduced mode set for pointer tables
// - multiply-accumulate pointers limited to working registers eight through eleven
// - registers eight and nine drive x generator, ten and eleven drive y
// - multiply-accumulate indexed mode only on register nine (x) or eleven (y)
// - multiply-accumulate modes: indirect, indexed, post-modified by 2, 4 or 6
// - branch target taken from a 16-bit signed literal in the word
// - interrupt-disable count is a 14-bit unsigned literal, zero extended
// - frame unlink operands implied by opcode; no-operation has no operands
`timescale 1ns/1ns
`default_nettype none
`include "opdec_defines.svh"
module operand_address_mode_decode (
  // clock, reset, enable
  input  wire logic                   REF_CLK,
  input  wire logic                   RESET_N,
  input  wire logic                   CLK_EN,
  // instruction from fetch
  input  wire logic                   INSTR_VALID,
  input  wire logic [23:0]            INSTR_WORD,
  input  wire opdec_pkg::regfile_t    WREG_FILE,
  // decode result
  output logic                        DEC_VALID,
  output logic                        DEC_ILLEGAL,
  output logic [3:0]                  DEC_CLASS,
  output logic [1:0]                  OPERAND_COUNT,
  output logic                        IMPLIED_OPERANDS,
  output logic [3:0]                  OFFSET_REG_NUM,
  // literals
  output logic                        LIT_VALID,
  output opdec_pkg::word_t            LIT_VALUE,
  output logic                        BRANCH_EN,
  output logic                        INTERRUPT_DISABLE_INSTR_EN,
  // x generator
  output logic                        X_ACTIVE,
  output logic                        X_DIRECT,
  output logic [3:0]                  X_PTR_NUM,
  output opdec_pkg::word_t            X_EA,
  output logic                        X_WB_EN,
  output opdec_pkg::word_t            X_WB_VALUE,
  // y generator
  output logic                        Y_ACTIVE,
  output logic                        Y_DIRECT,
  output logic [3:0]                  Y_PTR_NUM,
  output opdec_pkg::word_t            Y_EA,
  output logic                        Y_WB_EN,
  output opdec_pkg::word_t            Y_WB_VALUE
);
  logic              rst_meta_q;
  logic              rst_n_q;
  logic [3:0]        cls;
  logic              ill_d;
  logic [1:0]        cnt_d;
  logic              impl_d;
  logic              litv_d;
  logic              bra_d;
  logic              interrupt_disable_instr_d;
  opdec_pkg::word_t  lit_d;
  logic [3:0]        off_d;
  logic              xa_d;
  logic              ya_d;
  logic [3:0]        xn_d;
  logic [3:0]        yn_d;
  opdec_pkg::amode_t xm_d;
  opdec_pkg::amode_t ym_d;
  opdec_pkg::step_t  xs_d;
  opdec_pkg::step_t  ys_d;
  agu_if             xg ();
  agu_if             yg ();

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic opdec_pkg::word_t reg_value(input opdec_pkg::regfile_t f,
                                                 input logic [3:0] n);
    return f[{n, 4'h0} +: 16];
  endfunction

  // full set for move/accumulator, ordinary set excludes offset modes
  function automatic logic mode_ok(input opdec_pkg::amode_t m, input logic full);
    return full ? (m <= `AM_LITOFF) : (m <= `AM_PREDEC);
  endfunction

  function automatic opdec_pkg::amode_t mac_mode(input logic [2:0] m);
    return (m == `MM_INDEXED) ? `AM_INDEXED : ((m == `MM_IND) ? `AM_IND : `AM_POSTINC);
  endfunction

  function automatic opdec_pkg::step_t mac_step(input logic [2:0] m);
    return (m == `MM_POST2) ? 3'h2 : (m == `MM_POST4) ? 3'h4 : (m == `MM_POST6) ? 3'h6 : 3'h0;
  endfunction

  // literal offset mode reuses the shared offset field as the literal
  function automatic opdec_pkg::word_t offset_of(input opdec_pkg::amode_t m,
                                                 input logic [3:0] o,
                                                 input opdec_pkg::regfile_t f);
    return (m == `AM_LITOFF) ? {12'h000, o} : reg_value(f, o);
  endfunction

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else if (CLK_EN) begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // class decode
  // ------------------------------------------------------------
  assign cls = INSTR_WORD[`FLD_CLASS];

  always_comb begin
    ill_d  = 1'b0;
    cnt_d  = 2'h0;
    impl_d = 1'b0;
    litv_d = 1'b0;
    bra_d  = 1'b0;
    interrupt_disable_instr_d = 1'b0;
    lit_d  = 16'h0000;
    off_d  = INSTR_WORD[`FLD_OFFREG];
    xa_d   = 1'b0;
    ya_d   = 1'b0;
    xn_d   = INSTR_WORD[`FLD_SREG];
    yn_d   = INSTR_WORD[`FLD_DREG];
    xm_d   = INSTR_WORD[`FLD_SMODE];
    ym_d   = INSTR_WORD[`FLD_DMODE];
    xs_d   = `WORD_STEP;
    ys_d   = `WORD_STEP;
    unique case (cls)
      `CLS_NOP: begin
        cnt_d = 2'h0;
      end
      // independent modes per operand, one shared offset field
      `CLS_MOVE: begin
        xa_d  = 1'b1;
        ya_d  = 1'b1;
        cnt_d = 2'h2;
        ill_d = !mode_ok(xm_d, 1'b1) || !mode_ok(ym_d, 1'b1);
      end
      `CLS_ACC: begin
        xa_d  = 1'b1;
        cnt_d = 2'h1;
        ill_d = !mode_ok(xm_d, 1'b1);
      end
      `CLS_ORD: begin
        xa_d  = 1'b1;
        cnt_d = 2'h1;
        ill_d = !mode_ok(xm_d, 1'b0);
      end
      // pointer choice fixes the generator side
      `CLS_MAC: begin
        xa_d  = 1'b1;
        ya_d  = 1'b1;
        cnt_d = 2'h2;
        off_d = INSTR_WORD[`FLD_MAC_OFF];
        xn_d  = {`MAC_XBASE, INSTR_WORD[`FLD_MAC_XREG]};
        yn_d  = {`MAC_YBASE, INSTR_WORD[`FLD_MAC_YREG]};
        xm_d  = mac_mode(INSTR_WORD[`FLD_MAC_XMD]);
        ym_d  = mac_mode(INSTR_WORD[`FLD_MAC_YMD]);
        xs_d  = mac_step(INSTR_WORD[`FLD_MAC_XMD]);
        ys_d  = mac_step(INSTR_WORD[`FLD_MAC_YMD]);
        ill_d = (INSTR_WORD[`FLD_MAC_XMD] > `MM_INDEXED)
             || (INSTR_WORD[`FLD_MAC_YMD] > `MM_INDEXED)
             || (INSTR_WORD[`FLD_MAC_XMD] == `MM_INDEXED && !INSTR_WORD[`FLD_MAC_XREG])
             || (INSTR_WORD[`FLD_MAC_YMD] == `MM_INDEXED && !INSTR_WORD[`FLD_MAC_YREG]);
      end
      `CLS_BRA: begin
        lit_d  = INSTR_WORD[`FLD_BRA_LIT];
        litv_d = 1'b1;
        bra_d  = 1'b1;
        cnt_d  = 2'h1;
      end
      `CLS_INTERRUPT_DISABLE_INSTR: begin
        lit_d  = {2'h0, INSTR_WORD[`FLD_INTERRUPT_DISABLE_INSTR_LIT]};
        litv_d = 1'b1;
        interrupt_disable_instr_d = 1'b1;
        cnt_d  = 2'h1;
      end
      // frame pointer in, stack pointer out, nothing encoded
      `CLS_FRAME_UNLINK_INSTR: begin
        impl_d = 1'b1;
        xa_d   = 1'b1;
        ya_d   = 1'b1;
        xn_d   = `REG_FRAME;
        yn_d   = `REG_STACK;
        xm_d   = `AM_DIRECT;
        ym_d   = `AM_DIRECT;
      end
      `CLS_MOVL8: begin
        lit_d  = {8'h00, INSTR_WORD[`FLD_LIT8]};
        litv_d = 1'b1;
        ya_d   = 1'b1;
        yn_d   = INSTR_WORD[`FLD_SREG];
        ym_d   = `AM_DIRECT;
        cnt_d  = 2'h2;
      end
      `CLS_MOVL16: begin
        lit_d  = INSTR_WORD[`FLD_LIT16];
        litv_d = 1'b1;
        ya_d   = 1'b1;
        yn_d   = INSTR_WORD[`FLD_SREG];
        ym_d   = `AM_DIRECT;
        cnt_d  = 2'h2;
      end
      default: begin
        ill_d = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // address generators
  // ------------------------------------------------------------
  assign xg.mode   = xm_d;
  assign xg.step   = xs_d;
  assign xg.ptr    = reg_value(WREG_FILE, xn_d);
  assign xg.offset = offset_of(xm_d, off_d, WREG_FILE);
  assign yg.mode   = ym_d;
  assign yg.step   = ys_d;
  assign yg.ptr    = reg_value(WREG_FILE, yn_d);
  assign yg.offset = offset_of(ym_d, off_d, WREG_FILE);

  opdec_agu u_xgen (.a(xg.gen));
  opdec_agu u_ygen (.a(yg.gen));

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      DEC_VALID <= 1'b0;
    end else if (CLK_EN) begin
      DEC_VALID <= INSTR_VALID;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      DEC_ILLEGAL      <= 1'b0;
      DEC_CLASS        <= `CLS_NOP;
      OPERAND_COUNT    <= 2'h0;
      IMPLIED_OPERANDS <= 1'b0;
      OFFSET_REG_NUM   <= 4'h0;
      LIT_VALID        <= 1'b0;
      LIT_VALUE        <= 16'h0000;
      BRANCH_EN        <= 1'b0;
      INTERRUPT_DISABLE_INSTR_EN          <= 1'b0;
    end else if (CLK_EN && INSTR_VALID) begin
      DEC_ILLEGAL      <= ill_d;
      DEC_CLASS        <= cls;
      OPERAND_COUNT    <= cnt_d;
      IMPLIED_OPERANDS <= impl_d;
      OFFSET_REG_NUM   <= off_d;
      LIT_VALID        <= litv_d;
      LIT_VALUE        <= lit_d;
      BRANCH_EN        <= bra_d;
      INTERRUPT_DISABLE_INSTR_EN          <= interrupt_disable_instr_d;
    end
  end

  // illegal words never write a pointer back
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      X_ACTIVE   <= 1'b0;
      X_DIRECT   <= 1'b0;
      X_PTR_NUM  <= 4'h0;
      X_EA       <= 16'h0000;
      X_WB_EN    <= 1'b0;
      X_WB_VALUE <= 16'h0000;
      Y_ACTIVE   <= 1'b0;
      Y_DIRECT   <= 1'b0;
      Y_PTR_NUM  <= 4'h0;
      Y_EA       <= 16'h0000;
      Y_WB_EN    <= 1'b0;
      Y_WB_VALUE <= 16'h0000;
    end else if (CLK_EN && INSTR_VALID) begin
      X_ACTIVE   <= xa_d;
      X_DIRECT   <= xa_d && (xm_d == `AM_DIRECT);
      X_PTR_NUM  <= xn_d;
      X_EA       <= xg.ea;
      X_WB_EN    <= xa_d && !ill_d && xg.wb_en;
      X_WB_VALUE <= xg.wb_value;
      Y_ACTIVE   <= ya_d;
      Y_DIRECT   <= ya_d && (ym_d == `AM_DIRECT);
      Y_PTR_NUM  <= yn_d;
      Y_EA       <= yg.ea;
      Y_WB_EN    <= ya_d && !ill_d && yg.wb_en;
      Y_WB_VALUE <= yg.wb_value;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n_q);

  sequence issue(logic [3:0] c);
    CLK_EN && INSTR_VALID && cls == c;
  endsequence

  mac_x_side_a: assert property (issue(`CLS_MAC) |=> X_PTR_NUM[3:1] == 3'h4)
    else $error("mac x pointer not eight or nine");
  mac_y_side_a: assert property (issue(`CLS_MAC) |=> Y_PTR_NUM[3:1] == 3'h5)
    else $error("mac y pointer not ten or eleven");
  mac_index_a: assert property (issue(`CLS_MAC) ##0 (INSTR_WORD[`FLD_MAC_XMD] == `MM_INDEXED
      && !INSTR_WORD[`FLD_MAC_XREG]) |=> DEC_ILLEGAL && !X_WB_EN)
    else $error("mac indexed on register eight accepted");
  mac_post_a: assert property (issue(`CLS_MAC) ##0 (INSTR_WORD[`FLD_MAC_XMD] == `MM_POST6
      && !ill_d) |=> X_WB_EN && X_WB_VALUE == X_EA + 16'h0006)
    else $error("mac post-modify by six wrong");
  post_old_ptr_a: assert property (CLK_EN && INSTR_VALID && xa_d && xm_d == `AM_POSTINC
      |=> X_EA == $past(xg.ptr) && X_WB_VALUE == $past(xg.ptr) + {13'h0000, $past(xs_d)})
    else $error("post-modify used stepped pointer");
  ord_subset_a: assert property (issue(`CLS_ORD) ##0 (xm_d == `AM_INDEXED) |=> DEC_ILLEGAL)
    else $error("ordinary instruction took indexed mode");
  move_shared_a: assert property (issue(`CLS_MOVE) ##0 (ym_d == `AM_INDEXED
      && xm_d <= `AM_LITOFF)
      |=> Y_EA == $past(yg.ptr) + $past(yg.offset) && !DEC_ILLEGAL)
    else $error("move indexed address wrong");
  branch_lit_a: assert property (issue(`CLS_BRA)
      |=> BRANCH_EN && LIT_VALUE == $past(INSTR_WORD[`FLD_BRA_LIT]))
    else $error("branch literal wrong");
  interrupt_disable_instr_lit_a: assert property (issue(`CLS_INTERRUPT_DISABLE_INSTR)
      |=> INTERRUPT_DISABLE_INSTR_EN && LIT_VALUE == {2'h0, $past(INSTR_WORD[`FLD_INTERRUPT_DISABLE_INSTR_LIT])})
    else $error("disable count not zero extended");
  nop_none_a: assert property (issue(`CLS_NOP) |=> OPERAND_COUNT == 2'h0 && !X_ACTIVE)
    else $error("no-operation shows operands");
endmodule
`default_nettype wire

//--- operand_address_mode_decode_tb.sv
// self-checking bench of the operand addressing-mode decoder
`timescale 1ns/1ns
`default_nettype none
`include "opdec_defines.svh"
module operand_address_mode_decode_tb;
  logic                ref_clk, reset_n, clk_en, instr_valid;
  logic [23:0]         instr_word;
  opdec_pkg::regfile_t wreg_file;
  logic                dec_valid, dec_illegal, implied_operands, lit_valid, branch_en, interrupt_disable_instr_en;
  logic [3:0]          dec_class, offset_reg_num, x_ptr_num, y_ptr_num;
  logic [1:0]          operand_count;
  logic                x_active, x_direct, x_wb_en, y_active, y_direct, y_wb_en;
  opdec_pkg::word_t    lit_value, x_ea, x_wb_value, y_ea, y_wb_value;
  int                  errors;
  int                  num_checks;

  operand_address_mode_decode DUT (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .CLK_EN(clk_en),
    .INSTR_VALID(instr_valid), .INSTR_WORD(instr_word), .WREG_FILE(wreg_file),
    .DEC_VALID(dec_valid), .DEC_ILLEGAL(dec_illegal), .DEC_CLASS(dec_class),
    .OPERAND_COUNT(operand_count), .IMPLIED_OPERANDS(implied_operands),
    .OFFSET_REG_NUM(offset_reg_num), .LIT_VALID(lit_valid), .LIT_VALUE(lit_value),
    .BRANCH_EN(branch_en), .INTERRUPT_DISABLE_INSTR_EN(interrupt_disable_instr_en),
    .X_ACTIVE(x_active), .X_DIRECT(x_direct), .X_PTR_NUM(x_ptr_num), .X_EA(x_ea),
    .X_WB_EN(x_wb_en), .X_WB_VALUE(x_wb_value),
    .Y_ACTIVE(y_active), .Y_DIRECT(y_direct), .Y_PTR_NUM(y_ptr_num), .Y_EA(y_ea),
    .Y_WB_EN(y_wb_en), .Y_WB_VALUE(y_wb_value)
  );

  always #20 ref_clk = ~ref_clk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // distinct contents per register so a wrong pointer shows up
  function automatic opdec_pkg::word_t wv(input logic [3:0] n);
    return {4'h1, n, 8'h20};
  endfunction

  task automatic summarize();
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_nib(input string n, input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_word(input string n, input opdec_pkg::word_t e, input opdec_pkg::word_t g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // one word in, results checked at the following falling edge
  task automatic issue(input logic [23:0] w);
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr_word  = w;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    chk_bit("dec_valid", 1'b1, dec_valid);
    chk_nib("dec_class", w[23:20], dec_class);
  endtask

  task automatic side(input bit x, input logic [3:0] r, input logic dir, input logic we,
                      input opdec_pkg::word_t ea, input opdec_pkg::word_t wb);
    chk_bit("active", 1'b1, x ? x_active : y_active);
    chk_bit("direct", dir, x ? x_direct : y_direct);
    chk_nib("ptr_num", r, x ? x_ptr_num : y_ptr_num);
    chk_bit("wb_en", we, x ? x_wb_en : y_wb_en);
    if (we)
      chk_word("wb_value", wb, x ? x_wb_value : y_wb_value);
    if (!dir)
      chk_word("ea", ea, x ? x_ea : y_ea);
  endtask

  task automatic move_side(input bit x, input opdec_pkg::amode_t m, input logic [3:0] r,
                           input logic [3:0] o);
    opdec_pkg::word_t p;
    opdec_pkg::word_t ea;
    opdec_pkg::word_t wb;
    logic             we;
    p  = wv(r);
    ea = p;
    wb = p;
    we = 1'b0;
    case (m)
      `AM_POSTINC: begin we = 1'b1; wb = p + 16'h0002; end
      `AM_POSTDEC: begin we = 1'b1; wb = p - 16'h0002; end
      `AM_PREINC:  begin we = 1'b1; ea = p + 16'h0002; wb = ea; end
      `AM_PREDEC:  begin we = 1'b1; ea = p - 16'h0002; wb = ea; end
      `AM_INDEXED: ea = p + wv(o);
      `AM_LITOFF:  ea = p + {12'h000, o};
      default: ;
    endcase
    side(x, r, m == `AM_DIRECT, we, ea, wb);
  endtask

  task automatic mac_side(input bit x, input logic [2:0] m, input logic [3:0] r,
                          input logic [3:0] o);
    opdec_pkg::word_t p;
    p = wv(r);
    side(x, r, 1'b0, m >= `MM_POST2 && m <= `MM_POST6,
         m == `MM_INDEXED ? p + wv(o) : p, p + {12'h000, m, 1'b0});
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_move();
    opdec_pkg::amode_t sm;
    opdec_pkg::amode_t dm;
    for (int i = 0; i < 8; i++) begin
      sm = opdec_pkg::amode_t'(i);
      dm = opdec_pkg::amode_t'(7 - i);
      issue({`CLS_MOVE, 4'h3, dm, 4'h5, sm, 4'h2});
      chk_bit("dec_illegal", 1'b0, dec_illegal);
      chk_nib("offset_reg_num", 4'h3, offset_reg_num);
      chk_nib("operand_count", 4'h2, {2'b00, operand_count});
      move_side(1'b1, sm, 4'h2, 4'h3);
      move_side(1'b0, dm, 4'h5, 4'h3);
    end
    issue({`CLS_ACC, 4'h4, `AM_PREDEC, 4'h7, `AM_INDEXED, 4'h1});
    chk_bit("dec_illegal", 1'b0, dec_illegal);
    move_side(1'b1, `AM_INDEXED, 4'h1, 4'h4);
    chk_nib("operand_count", 4'h1, {2'b00, operand_count});
    chk_bit("y_active", 1'b0, y_active);
    chk_bit("y_wb_en", 1'b0, y_wb_en);
    issue({`CLS_MOVE, 4'h3, 4'h0, 4'h5, 4'h8, 4'h2});
    chk_bit("dec_illegal", 1'b1, dec_illegal);
    chk_bit("x_wb_en", 1'b0, x_wb_en);
  endtask

  task automatic t_ordinary();
    issue({`CLS_ORD, 4'h3, `AM_POSTINC, 4'h5, `AM_PREDEC, 4'h2});
    chk_bit("dec_illegal", 1'b0, dec_illegal);
    move_side(1'b1, `AM_PREDEC, 4'h2, 4'h3);
    chk_bit("y_active", 1'b0, y_active);
    issue({`CLS_ORD, 4'h3, `AM_POSTINC, 4'h5, `AM_INDEXED, 4'h2});
    chk_bit("dec_illegal", 1'b1, dec_illegal);
    issue({`CLS_ORD, 4'h3, `AM_IND, 4'h5, `AM_LITOFF, 4'h2});
    chk_bit("dec_illegal", 1'b1, dec_illegal);
    chk_bit("x_wb_en", 1'b0, x_wb_en);
  endtask

  task automatic t_mac();
    logic [2:0] xm;
    logic [2:0] ym;
    for (int i = 0; i < 5; i++) begin
      xm = 3'(i);
      ym = 3'(4 - i);
      issue({`CLS_MAC, 1'b1, xm, 1'b1, ym, 4'h3, 8'h00});
      chk_bit("dec_illegal", 1'b0, dec_illegal);
      mac_side(1'b1, xm, 4'h9, 4'h3);
      mac_side(1'b0, ym, 4'hb, 4'h3);
    end
    issue({`CLS_MAC, 1'b0, `MM_POST6, 1'b0, `MM_POST2, 4'h3, 8'h00});
    mac_side(1'b1, `MM_POST6, 4'h8, 4'h3);
    mac_side(1'b0, `MM_POST2, 4'ha, 4'h3);
    issue({`CLS_MAC, 1'b0, `MM_INDEXED, 1'b1, `MM_POST2, 4'h3, 8'h00});
    chk_bit("dec_illegal", 1'b1, dec_illegal);
    chk_bit("y_wb_en", 1'b0, y_wb_en);
    issue({`CLS_MAC, 1'b1, `MM_IND, 1'b0, `MM_INDEXED, 4'h3, 8'h00});
    chk_bit("dec_illegal", 1'b1, dec_illegal);
    issue({`CLS_MAC, 1'b1, 3'h5, 1'b1, `MM_IND, 4'h3, 8'h00});
    chk_bit("dec_illegal", 1'b1, dec_illegal);
  endtask

  task automatic t_literal();
    issue({`CLS_BRA, 4'hf, 16'h8001});
    chk_bit("branch_en", 1'b1, branch_en);
    chk_bit("lit_valid", 1'b1, lit_valid);
    chk_word("lit_value", 16'h8001, lit_value);
    issue({`CLS_INTERRUPT_DISABLE_INSTR, 4'hf, 16'heabc});
    chk_bit("interrupt_disable_instr_en", 1'b1, interrupt_disable_instr_en);
    chk_bit("branch_en", 1'b0, branch_en);
    chk_word("lit_value", 16'h2abc, lit_value);
    issue({`CLS_MOVL8, 8'h00, 8'ha5, 4'h6});
    chk_word("lit_value", 16'h00a5, lit_value);
    side(1'b0, 4'h6, 1'b1, 1'b0, 16'h0000, 16'h0000);
    issue({`CLS_MOVL16, 16'hbeef, 4'h7});
    chk_word("lit_value", 16'hbeef, lit_value);
  endtask

  task automatic t_implied();
    issue({`CLS_FRAME_UNLINK_INSTR, 20'h00000});
    chk_bit("implied_operands", 1'b1, implied_operands);
    chk_nib("operand_count", 4'h0, {2'b00, operand_count});
    side(1'b1, `REG_FRAME, 1'b1, 1'b0, 16'h0000, 16'h0000);
    side(1'b0, `REG_STACK, 1'b1, 1'b0, 16'h0000, 16'h0000);
    issue({`CLS_NOP, 20'h00000});
    chk_nib("operand_count", 4'h0, {2'b00, operand_count});
    chk_bit("x_active", 1'b0, x_active);
    chk_bit("y_active", 1'b0, y_active);
    chk_bit("dec_illegal", 1'b0, dec_illegal);
    issue({4'ha, 20'h00000});
    chk_bit("dec_illegal", 1'b1, dec_illegal);
  endtask

  // back-to-back words, then a word offered while the clock enable is low
  task automatic t_flow();
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr_word  = {`CLS_BRA, 4'h0, 16'h1234};
    @(negedge ref_clk);
    instr_word  = {`CLS_INTERRUPT_DISABLE_INSTR, 4'h0, 16'h0011};
    chk_bit("branch_en", 1'b1, branch_en);
    @(negedge ref_clk);
    instr_valid = 1'b0;
    chk_bit("dec_valid", 1'b1, dec_valid);
    chk_word("lit_value", 16'h0011, lit_value);
    @(negedge ref_clk);
    chk_bit("dec_valid", 1'b0, dec_valid);
    chk_bit("interrupt_disable_instr_en", 1'b1, interrupt_disable_instr_en);
    clk_en      = 1'b0;
    instr_valid = 1'b1;
    instr_word  = {`CLS_BRA, 4'h0, 16'h5555};
    @(negedge ref_clk);
    clk_en      = 1'b1;
    instr_valid = 1'b0;
    @(negedge ref_clk);
    chk_bit("branch_en", 1'b0, branch_en);
    chk_word("lit_value", 16'h0011, lit_value);
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    ref_clk     = 1'b0;
    reset_n     = 1'b0;
    clk_en      = 1'b1;
    instr_valid = 1'b0;
    instr_word  = 24'h000000;
    errors      = 0;
    num_checks  = 0;
    for (int n = 0; n < 16; n++)
      wreg_file[16*n +: 16] = wv(4'(n));
    repeat (20) @(negedge ref_clk);
    chk_bit("dec_valid", 1'b0, dec_valid);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_move();
    t_ordinary();
    t_mac();
    t_literal();
    t_implied();
    t_flow();
    summarize();
  end

  // the whole run is under a hundred cycles; this leaves ample margin
  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
